// File: pkg/rx_cfg_pkg.sv
`default_nettype none
package rx_cfg_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_OFFSET_ENABLES_AND_GAIN_STEPS = 6'h0C;
	localparam logic [5:0] IDX_OFFSET_RANGE_AND_DURATIONS    = 6'h0D;
	localparam logic [5:0] IDX_OFFSET_INTEGRATOR_CONSTANTS   = 6'h0E;
	localparam logic [5:0] IDX_RX_BASEBAND_OUTPUT_CONFIG     = 6'h0F;
	localparam logic [5:0] IDX_RX_STATUS                     = 6'h10;
	localparam logic [5:0] IDX_RX_GAIN_SETTING               = 6'h11;

	localparam int ADDR_IDX_LSB = 2;
	localparam int ADDR_IDX_W   = 6;

	// reset values
	localparam logic [11:0] RST_ENABLES_AND_STEPS  = 12'hFA6;
	localparam logic [15:0] RST_RANGE_AND_DURATION = 16'h103E;
	localparam logic [15:0] RST_INTEGRATORS        = 16'hEE53;
	localparam logic [11:0] RST_BB_OUTPUT_CONFIG   = 12'h090;
	localparam logic [6:0]  RST_GAIN_SETTING       = 7'h00;

	// field positions (lsb of each 3-, 4- or 5-bit field, or the bit of a 1-bit field)
	localparam int LSB_SDM_ENABLE  = 8;
	localparam int LSB_MIX_STEP    = 4;
	localparam int LSB_LNA_STEP    = 0;
	localparam int LSB_ADC_RANGE   = 12;
	localparam int LSB_DUR_TWO     = 8;
	localparam int LSB_DUR_ONE     = 4;
	localparam int LSB_DUR_ZERO    = 0;
	localparam int LSB_INT_THREE   = 12;
	localparam int LSB_INT_TWO     = 8;
	localparam int LSB_INT_ONE     = 4;
	localparam int LSB_INT_ZERO    = 0;
	localparam int BIT_VCM_HIGH    = 11;
	localparam int BIT_SWAP_Q      = 10;
	localparam int BIT_SWAP_I      = 9;
	localparam int LSB_FILTER_MODE = 6;
	localparam int LSB_GAIN_CAL    = 1;
	localparam int BIT_OSR_FOUR    = 0;

	typedef enum logic [2:0] {
		FILT_WCDMA_5TH = 3'b000,
		FILT_WCDMA_7TH = 3'b010,
		FILT_GSM       = 3'b111
	} filter_mode_t;

	localparam logic [4:0] GAIN_OFFSET_WCDMA = 5'h08;
	localparam logic [4:0] GAIN_OFFSET_GSM   = 5'h11;

	function automatic logic idx_mapped(input logic [5:0] idx);
		idx_mapped = (idx >= IDX_OFFSET_ENABLES_AND_GAIN_STEPS) && (idx <= IDX_RX_GAIN_SETTING);
	endfunction : idx_mapped

	function automatic logic idx_readable(input logic [5:0] idx);
		idx_readable = (idx == IDX_RX_STATUS) || (idx == IDX_RX_GAIN_SETTING);
	endfunction : idx_readable

endpackage : rx_cfg_pkg
`default_nettype wire

// File: pkg/cfg_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfg_bus_if;
	logic        wr_en;
	logic [5:0]  wr_idx;
	logic [15:0] wr_data;
	logic [5:0]  rd_idx;
	logic [15:0] rd_data;

	modport port (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : cfg_bus_if
`default_nettype wire

// File: verilog/apb_cfg_port.sv
`timescale 1ns/1ps
`default_nettype none
module apb_cfg_port
	import rx_cfg_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	cfg_bus_if.port          bus
);
	logic [5:0]  idx;
	logic [31:0] prdata_r;

	assign idx         = paddr[ADDR_IDX_LSB +: ADDR_IDX_W];
	// zero wait states: read data is captured in the setup cycle
	assign pready      = 1'b1;
	assign pslverr     = psel && penable && ((paddr[1:0] != 2'b00)
		|| (paddr[31:8] != 24'h000000) || !idx_mapped(idx));
	assign bus.wr_en   = psel && penable && pwrite && !pslverr;
	assign bus.wr_idx  = idx;
	assign bus.wr_data = pwdata[15:0];
	assign bus.rd_idx  = idx;
	assign prdata      = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= {16'h0000, bus.rd_data};
		end
	end

	wr_only_access_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus.wr_en |-> (psel && penable && pwrite)) else $error("write strobe outside access");
endmodule : apb_cfg_port
`default_nettype wire

// File: verilog/rx_bb_output.sv
`timescale 1ns/1ps
`default_nettype none
module rx_bb_output (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic swap_i,
	input  wire logic swap_q,
	input  wire logic bb_i_p,
	input  wire logic bb_i_n,
	input  wire logic bb_q_p,
	input  wire logic bb_q_n,
	output var  logic i_out_positive,
	output var  logic i_out_negative,
	output var  logic q_out_positive,
	output var  logic q_out_negative
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i_out_positive <= 1'b0;
			i_out_negative <= 1'b0;
		end else begin
			i_out_positive <= swap_i ? bb_i_n : bb_i_p;
			i_out_negative <= swap_i ? bb_i_p : bb_i_n;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_out_positive <= 1'b0;
			q_out_negative <= 1'b0;
		end else begin
			q_out_positive <= swap_q ? bb_q_n : bb_q_p;
			q_out_negative <= swap_q ? bb_q_p : bb_q_n;
		end
	end
endmodule : rx_bb_output
`default_nettype wire

// File: verilog/rx_offset_gain_filter_config.sv
`timescale 1ns/1ps
`default_nettype none
module rx_offset_gain_filter_config
	import rx_cfg_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        bb_i_p,
	input  wire logic        bb_i_n,
	input  wire logic        bb_q_p,
	input  wire logic        bb_q_n,
	output var  logic        i_out_positive,
	output var  logic        i_out_negative,
	output var  logic        q_out_positive,
	output var  logic        q_out_negative,
	output var  logic [3:0]  offset_mod_enable,
	output var  logic [3:0]  mixer_gain_threshold,
	output var  logic [3:0]  lna_gain_threshold,
	output var  logic [3:0]  offset_adc_range,
	output var  logic [3:0]  state_two_duration,
	output var  logic [3:0]  state_one_duration,
	output var  logic [3:0]  state_zero_duration,
	output var  logic [3:0]  state_three_integrator,
	output var  logic [3:0]  state_two_integrator,
	output var  logic [3:0]  state_one_integrator,
	output var  logic [3:0]  state_zero_integrator,
	output var  logic        output_cm_high,
	output var  logic [2:0]  filter_mode,
	output var  logic        filter_wcdma_5th,
	output var  logic        filter_wcdma_7th,
	output var  logic        filter_gsm,
	output var  logic        filter_reserved,
	output var  logic [4:0]  gain_cal,
	output var  logic        osr_four_x,
	output var  logic [8:0]  effective_gain
);
	cfg_bus_if bus ();

	logic [11:0] steps_r;
	logic [15:0] durations_r;
	logic [15:0] integrators_r;
	logic [11:0] bb_cfg_r;
	logic [6:0]  gain_setting_r;
	logic [8:0]  eff_gain_r;
	logic [8:0]  eff_gain_nxt;
	logic [4:0]  gain_offset;
	logic        wr_steps;
	logic        wr_durations;
	logic        wr_integrators;
	logic        wr_bb_cfg;
	logic        wr_gain;

	function automatic logic wr_hit(input logic en, input logic [5:0] idx,
			input logic [5:0] target);
		wr_hit = en && (idx == target);
	endfunction : wr_hit

	apb_cfg_port u_port (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.bus     (bus.port)
	);

	assign wr_steps       = wr_hit(bus.wr_en, bus.wr_idx, IDX_OFFSET_ENABLES_AND_GAIN_STEPS);
	assign wr_durations   = wr_hit(bus.wr_en, bus.wr_idx, IDX_OFFSET_RANGE_AND_DURATIONS);
	assign wr_integrators = wr_hit(bus.wr_en, bus.wr_idx, IDX_OFFSET_INTEGRATOR_CONSTANTS);
	assign wr_bb_cfg      = wr_hit(bus.wr_en, bus.wr_idx, IDX_RX_BASEBAND_OUTPUT_CONFIG);
	assign wr_gain        = wr_hit(bus.wr_en, bus.wr_idx, IDX_RX_GAIN_SETTING);

	// configuration words load defaults at reset and move only on their own write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			steps_r <= RST_ENABLES_AND_STEPS;
		end else if (wr_steps) begin
			// skip-state bits 15:12 are not kept
			steps_r <= bus.wr_data[11:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			durations_r <= RST_RANGE_AND_DURATION;
		end else if (wr_durations) begin
			durations_r <= bus.wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			integrators_r <= RST_INTEGRATORS;
		end else if (wr_integrators) begin
			integrators_r <= bus.wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bb_cfg_r <= RST_BB_OUTPUT_CONFIG;
		end else if (wr_bb_cfg) begin
			// bits 15:12 of the word are unused
			bb_cfg_r <= bus.wr_data[11:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_setting_r <= RST_GAIN_SETTING;
		end else if (wr_gain) begin
			gain_setting_r <= bus.wr_data[6:0];
		end
	end

	// field fan-out
	assign offset_mod_enable      = steps_r[LSB_SDM_ENABLE +: 4];
	assign mixer_gain_threshold   = steps_r[LSB_MIX_STEP +: 4];
	assign lna_gain_threshold     = steps_r[LSB_LNA_STEP +: 4];
	assign offset_adc_range       = durations_r[LSB_ADC_RANGE +: 4];
	assign state_two_duration     = durations_r[LSB_DUR_TWO +: 4];
	assign state_one_duration     = durations_r[LSB_DUR_ONE +: 4];
	assign state_zero_duration    = durations_r[LSB_DUR_ZERO +: 4];
	assign state_three_integrator = integrators_r[LSB_INT_THREE +: 4];
	assign state_two_integrator   = integrators_r[LSB_INT_TWO +: 4];
	assign state_one_integrator   = integrators_r[LSB_INT_ONE +: 4];
	assign state_zero_integrator  = integrators_r[LSB_INT_ZERO +: 4];
	assign output_cm_high         = bb_cfg_r[BIT_VCM_HIGH];
	assign filter_mode            = bb_cfg_r[LSB_FILTER_MODE +: 3];
	// value is taken as written; software owns the 8-when-uncalibrated choice
	assign gain_cal               = bb_cfg_r[LSB_GAIN_CAL +: 5];
	assign osr_four_x             = bb_cfg_r[BIT_OSR_FOUR];

	// filter decode
	always_comb begin
		filter_wcdma_5th = 1'b0;
		filter_wcdma_7th = 1'b0;
		filter_gsm       = 1'b0;
		filter_reserved  = 1'b0;
		unique case (filter_mode)
			FILT_WCDMA_5TH: filter_wcdma_5th = 1'b1;
			FILT_WCDMA_7TH: filter_wcdma_7th = 1'b1;
			FILT_GSM:       filter_gsm       = 1'b1;
			default:        filter_reserved  = 1'b1;
		endcase
	end

	// reserved filter codes fall back to the WCDMA offset
	assign gain_offset  = filter_gsm ? GAIN_OFFSET_GSM : GAIN_OFFSET_WCDMA;
	// nine bits, two's complement: a small gain with large calibration goes negative
	assign eff_gain_nxt = {2'b00, gain_setting_r} - {4'h0, gain_cal}
		+ {4'h0, gain_offset};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_gain_r <= 9'h000;
		end else begin
			eff_gain_r <= eff_gain_nxt;
		end
	end

	assign effective_gain = eff_gain_r;

	// configuration words other than the gain setting are write-only and read as zero
	always_comb begin
		bus.rd_data = 16'h0000;
		if (bus.rd_idx == IDX_RX_STATUS) begin
			bus.rd_data = {5'h00, filter_reserved, filter_gsm, eff_gain_r};
		end else if (bus.rd_idx == IDX_RX_GAIN_SETTING) begin
			bus.rd_data = {9'h000, gain_setting_r};
		end
	end

	rx_bb_output u_bb (
		.pclk           (pclk),
		.presetn        (presetn),
		.swap_i         (bb_cfg_r[BIT_SWAP_I]),
		.swap_q         (bb_cfg_r[BIT_SWAP_Q]),
		.bb_i_p         (bb_i_p),
		.bb_i_n         (bb_i_n),
		.bb_q_p         (bb_q_p),
		.bb_q_n         (bb_q_n),
		.i_out_positive (i_out_positive),
		.i_out_negative (i_out_negative),
		.q_out_positive (q_out_positive),
		.q_out_negative (q_out_negative)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sdm_enable_load_a: assert property (
		wr_steps |=> offset_mod_enable == $past(bus.wr_data[11:8]))
		else $error("modulator enable not loaded");

	mix_step_load_a: assert property (
		wr_steps |=> mixer_gain_threshold == $past(bus.wr_data[7:4]))
		else $error("mixer threshold not loaded");

	lna_step_load_a: assert property (
		wr_steps |=> lna_gain_threshold == $past(bus.wr_data[3:0]))
		else $error("lna threshold not loaded");

	adc_range_load_a: assert property (
		wr_durations |=> {offset_adc_range, state_two_duration}
			== $past(bus.wr_data[15:8]))
		else $error("range or duration not loaded");

	durations_low_a: assert property (
		wr_durations |=> {state_one_duration, state_zero_duration}
			== $past(bus.wr_data[7:0]))
		else $error("low durations not loaded");

	integrators_load_a: assert property (
		wr_integrators |=> {state_three_integrator, state_two_integrator,
			state_one_integrator, state_zero_integrator} == $past(bus.wr_data))
		else $error("integrator constants not loaded");

	cm_select_load_a: assert property (
		wr_bb_cfg |=> output_cm_high == $past(bus.wr_data[11]))
		else $error("common mode select not loaded");

	// legs stay cleared for one edge after reset leaves, so wait for a clocked cycle
	q_leg_swap_a: assert property (
		$past(presetn) |-> q_out_positive
			== ($past(bb_cfg_r[BIT_SWAP_Q]) ? $past(bb_q_n) : $past(bb_q_p)))
		else $error("q legs wrong");

	i_leg_swap_a: assert property (
		$past(presetn) |-> i_out_negative
			== ($past(bb_cfg_r[BIT_SWAP_I]) ? $past(bb_i_p) : $past(bb_i_n)))
		else $error("i legs wrong");

	filter_gsm_decode_a: assert property (
		wr_bb_cfg && (bus.wr_data[8:6] == 3'b111) |=> filter_gsm && !filter_reserved)
		else $error("gsm code not decoded");

	filter_rsvd_decode_a: assert property (
		filter_reserved == !(filter_mode == 3'b000 || filter_mode == 3'b010
			|| filter_mode == 3'b111))
		else $error("reserved decode wrong");

	filter_mode_load_a: assert property (
		wr_bb_cfg |=> filter_mode == $past(bus.wr_data[8:6]))
		else $error("filter mode not loaded");

	filter_one_hot_a: assert property (
		$onehot({filter_wcdma_5th, filter_wcdma_7th, filter_gsm, filter_reserved}))
		else $error("filter decode not one-hot");

	gain_cal_load_a: assert property (
		wr_bb_cfg |=> gain_cal == $past(bus.wr_data[5:1]))
		else $error("gain calibration not loaded");

	osr_select_load_a: assert property (
		wr_bb_cfg |=> osr_four_x == $past(bus.wr_data[0]))
		else $error("oversampling select not loaded");

	eff_gain_gsm_a: assert property (
		filter_gsm |=> effective_gain
			== 9'($past({2'b00, gain_setting_r}) - $past({4'h0, gain_cal}) + 9'd17))
		else $error("gsm effective gain wrong");

	eff_gain_wcdma_a: assert property (
		!filter_gsm |=> effective_gain
			== 9'($past({2'b00, gain_setting_r}) - $past({4'h0, gain_cal}) + 9'd8))
		else $error("wcdma effective gain wrong");

	steps_hold_a: assert property (
		!wr_steps |=> $stable(steps_r))
		else $error("steps word moved without write");

	bb_cfg_hold_a: assert property (
		!wr_bb_cfg && !wr_durations |=> $stable(bb_cfg_r) && $stable(durations_r))
		else $error("config word moved without write");

	integrators_hold_a: assert property (
		!wr_integrators |=> $stable(integrators_r))
		else $error("integrator word moved without write");
endmodule : rx_offset_gain_filter_config
`default_nettype wire

// File: sim/rx_offset_gain_filter_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rx_offset_gain_filter_config_tb_top;
	import rx_cfg_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  bb_in;
	logic [3:0]  legs;
	logic [3:0]  mod_en, mix_th, lna_th, adc_rng, dur2, dur1, dur0, int3, int2, int1, int0;
	logic        cm_high, f5, f7, fg, fr, osr4;
	logic [2:0]  fmode;
	logic [4:0]  gcal;
	logic [8:0]  eff;
	logic [31:0] rd;
	logic [8:0]  eff_exp;
	logic [3:0]  dec_exp;
	int          mismatches;
	int          compares;
	int          cycles;

	rx_offset_gain_filter_config i_rx_offset_gain_filter_config (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bb_i_p(bb_in[3]), .bb_i_n(bb_in[2]), .bb_q_p(bb_in[1]), .bb_q_n(bb_in[0]),
		.i_out_positive(legs[3]), .i_out_negative(legs[2]),
		.q_out_positive(legs[1]), .q_out_negative(legs[0]),
		.offset_mod_enable(mod_en), .mixer_gain_threshold(mix_th), .lna_gain_threshold(lna_th),
		.offset_adc_range(adc_rng), .state_two_duration(dur2), .state_one_duration(dur1),
		.state_zero_duration(dur0), .state_three_integrator(int3), .state_two_integrator(int2),
		.state_one_integrator(int1), .state_zero_integrator(int0), .output_cm_high(cm_high),
		.filter_mode(fmode), .filter_wcdma_5th(f5), .filter_wcdma_7th(f7), .filter_gsm(fg),
		.filter_reserved(fr), .gain_cal(gcal), .osr_four_x(osr4), .effective_gain(eff)
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic final_report;
		if (mismatches == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			mismatches++;
		end
	endtask : check

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : settle

	// one transfer; waits for pready under a bound instead of assuming zero wait states
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			input logic err_exp, output logic [31:0] data);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) mismatches++;
		data = prdata;
		check("pslverr", pslverr, err_exp);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic check_defaults;
		check("enables_steps", {mod_en, mix_th, lna_th}, 12'hFA6);
		check("range_durations", {adc_rng, dur2, dur1, dur0}, 16'h103E);
		check("integrators", {int3, int2, int1, int0}, 16'hEE53);
		check("bb_config", {cm_high, fmode, gcal, osr4},
			{1'b0, 3'b010, 5'h08, 1'b0});
	endtask : check_defaults

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		mismatches = 0;
		compares = 0;
		cycles = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		bb_in = 4'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		check_defaults();
		// each write must touch only its own word
		apb(1'b1, 32'h30, 32'h0000_0123, 1'b0, rd);
		settle(2);
		check("enables_steps write", {mod_en, mix_th, lna_th}, 12'h123);
		check("range_durations kept", {adc_rng, dur2, dur1, dur0}, 16'h103E);
		apb(1'b1, 32'h34, 32'h0000_A5C7, 1'b0, rd);
		apb(1'b1, 32'h38, 32'h0000_19F0, 1'b0, rd);
		settle(2);
		check("range_durations write", {adc_rng, dur2, dur1, dur0}, 16'hA5C7);
		check("integrators write", {int3, int2, int1, int0}, 16'h19F0);
		check("enables_steps kept", {mod_en, mix_th, lna_th}, 12'h123);
		// refused and write-only accesses
		apb(1'b1, 32'h130, 32'h0000_0FFF, 1'b1, rd);
		apb(1'b0, 32'h80, 32'h0, 1'b1, rd);
		apb(1'b0, 32'h31, 32'h0, 1'b1, rd);
		apb(1'b0, 32'h30, 32'h0, 1'b0, rd);
		check("write-only read", rd, 32'h0);
		settle(1);
		check("enables_steps after refusal", {mod_en, mix_th, lna_th}, 12'h123);
		// every filter code, with calibration driving the gain below zero for codes 2 to 7
		apb(1'b1, 32'h44, 32'h0000_0002, 1'b0, rd);
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, 32'h3C, {20'h0, m[0], 2'b00, m[2:0], m[2:0], 2'b11, m[1]}, 1'b0, rd);
			settle(2);
			check("bb_config", {cm_high, fmode, gcal, osr4},
				{m[0], m[2:0], m[2:0], 2'b11, m[1]});
			dec_exp = (m == 0) ? 4'b1000 : (m == 2) ? 4'b0100 : (m == 7) ? 4'b0010 : 4'b0001;
			check("filter decode", {f5, f7, fg, fr}, dec_exp);
			eff_exp = 9'h002 - {4'h0, m[2:0], 2'b11} + ((m == 7) ? 9'h011 : 9'h008);
			check("effective gain", eff, eff_exp);
			apb(1'b0, 32'h40, 32'h0, 1'b0, rd);
			check("status", rd, {16'h0, 5'h00, dec_exp[0], dec_exp[1], eff_exp});
		end
		// status is read-only and takes no error
		apb(1'b1, 32'h40, 32'h0000_FFFF, 1'b0, rd);
		apb(1'b0, 32'h40, 32'h0, 1'b0, rd);
		check("status kept", rd, {16'h0, 5'h00, 1'b0, 1'b1, eff_exp});
		// leg exchange over all swap settings and all input patterns
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, 32'h3C, {21'h0, s[1], s[0], 3'b010, 5'h08, 1'b0}, 1'b0, rd);
			for (int p = 0; p < 16; p++) begin
				@(posedge pclk);
				bb_in <= p[3:0];
				settle(2);
				check("i legs", legs[3:2], s[0] ? {p[2], p[3]} : p[3:2]);
				check("q legs", legs[1:0], s[1] ? {p[0], p[1]} : p[1:0]);
			end
		end
		// mid-run reset brings every field back
		@(posedge pclk);
		presetn <= 1'b0;
		settle(2);
		check_defaults();
		@(posedge pclk);
		presetn <= 1'b1;
		settle(2);
		check_defaults();
		check("effective gain reset", eff, 9'h000);
		final_report();
	end
endmodule : rx_offset_gain_filter_config_tb_top
`default_nettype wire
